//--- tb/mad_debug_regs_tb_top.sv
// self-checking bench of the motor algorithm debug register bank
module mad_debug_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk;
    logic               nrst;
    logic               reg_wr;
    logic               reg_rd;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata;
    logic [31:0]        reg_rdata;
    logic               reg_ack;
    logic               loops_disable;
    logic signed [10:0] vd_ref_num;
    logic signed [10:0] vq_ref_num;
    logic               volt_code_invalid;
    logic [9:0]         inner_ki;
    logic [9:0]         inner_kp;
    logic [9:0]         vel_ki;
    logic [9:0]         vel_kp;
    logic               meas_busy;
    logic               meas_step_req;
    logic [1:0]         meas_step_sel;
    logic               meas_step_done;
    logic               shadow_store;
    int                 err_total;
    int                 n_checks;
    int                 cycles;
    logic [31:0]        rd;
    logic [9:0]         codes [6];
    logic [10:0]        e_vd;
    logic [10:0]        e_vq;

    mad_debug_regs u_mad_debug_regs (
        .ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .loops_disable(loops_disable), .vd_ref_num(vd_ref_num),
        .vq_ref_num(vq_ref_num), .volt_code_invalid(volt_code_invalid),
        .inner_ki(inner_ki), .inner_kp(inner_kp), .vel_ki(vel_ki), .vel_kp(vel_kp),
        .meas_busy(meas_busy), .meas_step_req(meas_step_req),
        .meas_step_sel(meas_step_sel), .meas_step_done(meas_step_done),
        .shadow_store(shadow_store)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // returns inside the ack cycle, so pulses caused by the write are visible
    task automatic reg_write(input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= mad_pkg::OVR_CTRL_OFFSET;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
        chk({31'h0, reg_ack}, 32'h0000_0001);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk({31'h0, reg_ack}, 32'h0000_0001);
        d = reg_rdata;
    endtask

    task automatic pulse_done();
        @(posedge ref_clk);
        meas_step_done <= 1'b1;
        @(posedge ref_clk);
        meas_step_done <= 1'b0;
        #1;
    endtask

    // m holds the enables in bit order res, ind, bemf, mech from msb down
    task automatic run_meas(input logic [3:0] m, input logic poke);
        reg_write({26'h0, 1'b1, m, 1'b0});
        @(posedge ref_clk);
        #1;
        for (int s = 0; s < 4; s++) begin
            if (m[3-s]) begin
                chk({30'h0, meas_step_req, meas_busy}, 32'h0000_0003);
                chk({30'h0, meas_step_sel}, s[31:0]);
                if (poke) begin
                    // a second start with other enables must not disturb the run
                    reg_write(32'h0000_003E);
                    reg_read(mad_pkg::OVR_CTRL_OFFSET, rd);
                    chk(rd & 32'h0000_0020, 32'h0000_0020);
                    poke = 1'b0;
                end
                pulse_done();
            end
        end
        chk({30'h0, meas_step_req, meas_busy}, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        cycles = 0;
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        inner_ki = 10'h3FF;
        inner_kp = 10'h155;
        vel_ki = 10'h2AA;
        vel_kp = 10'h001;
        meas_step_done = 1'b0;
        codes = '{10'h000, 10'h1F3, 10'h1F4, 10'h200, 10'h201, 10'h3E8};
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset state and an unmapped place
        reg_read(mad_pkg::OVR_CTRL_OFFSET, rd);
        chk(rd, 32'h0000_0000);
        chk({31'h0, loops_disable}, 32'h0000_0000);
        reg_read(8'h10, rd);
        chk(rd, 32'h0000_0000);
        // gain readback, zero padding above each 10-bit field
        reg_read(mad_pkg::INNER_GAIN_OFFSET, rd);
        chk(rd, {6'h00, inner_ki, 6'h00, inner_kp});
        reg_read(mad_pkg::VEL_GAIN_OFFSET, rd);
        chk(rd, {6'h00, vel_ki, 6'h00, vel_kp});
        @(posedge ref_clk);
        inner_ki <= 10'h001;
        vel_kp <= 10'h3FE;
        reg_read(mad_pkg::INNER_GAIN_OFFSET, rd);
        chk(rd, {6'h00, 10'h001, 6'h00, inner_kp});
        reg_read(mad_pkg::VEL_GAIN_OFFSET, rd);
        chk(rd, {6'h00, vel_ki, 6'h00, 10'h3FE});
        // forced voltages across the decode boundaries, reserved bits written high
        for (int i = 0; i < 6; i++) begin
            e_vd = (codes[i] > 10'h200) ? {1'b0, codes[i]} - 11'h400 : {1'b0, codes[i]};
            e_vq = (codes[5-i] > 10'h200) ? {1'b0, codes[5-i]} - 11'h400 : {1'b0, codes[5-i]};
            reg_write({5'h1F, 1'b1, codes[i], codes[5-i], 6'h00});
            chk({31'h0, loops_disable}, 32'h0000_0001);
            chk({21'h0, vd_ref_num}, {21'h0, e_vd});
            chk({21'h0, vq_ref_num}, {21'h0, e_vq});
            chk({31'h0, volt_code_invalid}, 32'h0000_0000);
            reg_read(mad_pkg::OVR_CTRL_OFFSET, rd);
            chk(rd, {5'h00, 1'b1, codes[i], codes[5-i], 6'h00});
        end
        // out-of-range code only flagged
        reg_write({6'h01, 10'h1F5, 10'h000, 6'h00});
        chk({31'h0, volt_code_invalid}, 32'h0000_0001);
        reg_write({6'h01, 10'h000, 10'h3E9, 6'h00});
        chk({31'h0, volt_code_invalid}, 32'h0000_0001);
        // loops back on: references released
        reg_write({6'h00, 10'h1F4, 10'h1F4, 6'h00});
        chk({31'h0, loops_disable}, 32'h0000_0000);
        chk({10'h0, vd_ref_num, vq_ref_num}, 32'h0000_0000);
        // shadow copy is a single pulse in the ack cycle
        reg_write(32'h0000_0001);
        chk({31'h0, shadow_store}, 32'h0000_0001);
        @(posedge ref_clk);
        #1;
        chk({31'h0, shadow_store}, 32'h0000_0000);
        // stray done while idle must not start anything
        pulse_done();
        chk({31'h0, meas_busy}, 32'h0000_0000);
        run_meas(4'hA, 1'b1);
        run_meas(4'h5, 1'b0);
        run_meas(4'hF, 1'b0);
        run_meas(4'h0, 1'b0);
        run_meas(4'h1, 1'b0);
        conclude();
    end
endmodule

//--- verilog/mad_debug_regs.sv
// motor algorithm debug register bank: loop override, measurement control, gain readback
//
// Behaviour
// - with the bypass bit 26 set both loops are disabled and the forced voltages drive Vd/Vq.
// - the forced direct field (25-16) is raw/500 below 500 and (raw-1024)/500 above 512.
// - the forced quadrature field (15-6) decodes the same way as the direct field.
// - writing one to bit 5 starts the motor parameter measurement routine.
// - resistance is measured only when bit 4 is one.
// - inductance is measured only when bit 3 is one.
// - back-EMF constant is measured only when bit 2 is one.
// - mechanical parameters are measured only when bit 1 is one.
// - writing one to bit 0 copies measured parameters into the shadow registers.
// - the inner gain readback shows the current-loop integral gain in bits 31-16 (10 bits).
// - the inner gain readback shows the current-loop proportional gain in bits 15-0.
// - the velocity gain readback shows speed-loop integral 31-16 and proportional 15-0.
module mad_debug_regs (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    // register port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    output logic [31:0]             reg_rdata,
    output logic                    reg_ack,
    // loop override to the control algorithm
    output logic                    loops_disable,
    output logic signed [10:0]      vd_ref_num,
    output logic signed [10:0]      vq_ref_num,
    output logic                    volt_code_invalid,
    // gains in use
    input  wire logic [9:0]         inner_ki,
    input  wire logic [9:0]         inner_kp,
    input  wire logic [9:0]         vel_ki,
    input  wire logic [9:0]         vel_kp,
    // measurement engine
    output logic                    meas_busy,
    output logic                    meas_step_req,
    output logic [1:0]              meas_step_sel,
    input  wire logic               meas_step_done,
    output logic                    shadow_store
);

    typedef struct packed {
        logic              bypass;
        logic [9:0]        vd_raw;
        logic [9:0]        vq_raw;
        logic [3:0]        en;
        logic signed [10:0] vd_num;
        logic signed [10:0] vq_num;
        logic              invalid;
        logic              start;
        logic              shadow;
        logic [31:0]       rdata;
        logic              ack;
    } mad_regs_state_type;

    mad_regs_state_type r_q;
    mad_regs_state_type r_d;

    mad_meas_if meas ();

    logic       wr_ovr;
    logic [9:0] vd_code;
    logic [9:0] vq_code;

    assign wr_ovr  = reg_wr && (reg_addr == mad_pkg::OVR_CTRL_OFFSET);
    assign vd_code = reg_wdata[mad_pkg::VD_MSB:mad_pkg::VD_LSB];
    assign vq_code = reg_wdata[mad_pkg::VQ_MSB:mad_pkg::VQ_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_d        = r_q;
        r_d.start  = 1'b0;
        r_d.shadow = 1'b0;
        r_d.ack    = reg_wr || reg_rd;
        if (wr_ovr) begin
            r_d.bypass = reg_wdata[mad_pkg::BYPASS_BIT];
            r_d.vd_raw = vd_code;
            r_d.vq_raw = vq_code;
            r_d.en     = {reg_wdata[mad_pkg::EN_RES_BIT], reg_wdata[mad_pkg::EN_IND_BIT],
                          reg_wdata[mad_pkg::EN_BEMF_BIT], reg_wdata[mad_pkg::EN_MECH_BIT]};
            // a start while a run is busy is dropped by the sequencer
            r_d.start  = reg_wdata[mad_pkg::START_BIT];
            r_d.shadow = reg_wdata[mad_pkg::SHADOW_BIT];
            // decoded in the write cycle so reference and mode change together
            r_d.vd_num = mad_pkg::decode_volt(vd_code);
            r_d.vq_num = mad_pkg::decode_volt(vq_code);
            // out-of-range codes are flagged, not clamped
            r_d.invalid = mad_pkg::volt_invalid(vd_code) ||
                          mad_pkg::volt_invalid(vq_code);
        end
        r_d.rdata = mad_pkg::RDATA_RESET;
        if (reg_rd) begin
            unique case (reg_addr)
                mad_pkg::OVR_CTRL_OFFSET: begin
                    // bits 31-27 stay zero; bit 5 reads back the run in progress
                    r_d.rdata[mad_pkg::BYPASS_BIT]             = r_q.bypass;
                    r_d.rdata[mad_pkg::VD_MSB:mad_pkg::VD_LSB] = r_q.vd_raw;
                    r_d.rdata[mad_pkg::VQ_MSB:mad_pkg::VQ_LSB] = r_q.vq_raw;
                    r_d.rdata[mad_pkg::START_BIT]              = meas.busy;
                    r_d.rdata[mad_pkg::EN_RES_BIT:mad_pkg::EN_MECH_BIT] = r_q.en;
                end
                mad_pkg::INNER_GAIN_OFFSET: begin
                    r_d.rdata[mad_pkg::GAIN_HI_LSB +: mad_pkg::GAIN_W] = inner_ki;
                    r_d.rdata[mad_pkg::GAIN_LO_LSB +: mad_pkg::GAIN_W] = inner_kp;
                end
                mad_pkg::VEL_GAIN_OFFSET: begin
                    r_d.rdata[mad_pkg::GAIN_HI_LSB +: mad_pkg::GAIN_W] = vel_ki;
                    r_d.rdata[mad_pkg::GAIN_LO_LSB +: mad_pkg::GAIN_W] = vel_kp;
                end
                default: begin
                    r_d.rdata = mad_pkg::RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r_q <= '{bypass: 1'b0, vd_raw: mad_pkg::VOLT_RESET, vq_raw: mad_pkg::VOLT_RESET,
                     en: mad_pkg::EN_RESET, vd_num: '0, vq_num: '0, invalid: 1'b0,
                     start: 1'b0, shadow: 1'b0, rdata: mad_pkg::RDATA_RESET, ack: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs and sequencer

    assign loops_disable     = r_q.bypass;
    // forced references only reach the algorithm while the loops are bypassed
    assign vd_ref_num        = r_q.bypass ? r_q.vd_num : '0;
    assign vq_ref_num        = r_q.bypass ? r_q.vq_num : '0;
    assign volt_code_invalid = r_q.invalid;
    assign reg_rdata         = r_q.rdata;
    assign reg_ack           = r_q.ack;
    assign shadow_store      = r_q.shadow;
    assign meas.start        = r_q.start;
    assign meas.en           = r_q.en;
    assign meas_busy         = meas.busy;

    mad_meas_seq u_seq (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .meas      (meas),
        .step_req  (meas_step_req),
        .step_sel  (meas_step_sel),
        .step_done (meas_step_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // low ten bits of either decode equal the raw code, so no decoder is reused here
    property p_bypass;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && reg_wdata[mad_pkg::BYPASS_BIT])
            |=> loops_disable && (vq_ref_num[9:0] == $past(vq_code));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not force references");

    property p_release;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && !reg_wdata[mad_pkg::BYPASS_BIT])
            |=> !loops_disable && (vd_ref_num == 11'sh000) && (vq_ref_num == 11'sh000);
    endproperty
    a_release: assert property (p_release) else $error("references not released");

    property p_vd_pos;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && reg_wdata[mad_pkg::BYPASS_BIT] && (vd_code < mad_pkg::VOLT_POS_LIMIT))
            |=> (vd_ref_num == $signed({1'b0, $past(vd_code)}));
    endproperty
    a_vd_pos: assert property (p_vd_pos) else $error("positive vd code decoded wrong");

    // a set top bit over the raw code is the raw code minus 1024
    property p_vq_neg;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && reg_wdata[mad_pkg::BYPASS_BIT] && (vq_code > mad_pkg::VOLT_NEG_START))
            |=> (vq_ref_num < 0) &&
                (vq_ref_num == $signed({1'b1, $past(vq_code)}));
    endproperty
    a_vq_neg: assert property (p_vq_neg) else $error("negative vq code decoded wrong");

    property p_invalid;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && (((vd_code > mad_pkg::VOLT_POS_LIMIT) && (vd_code < mad_pkg::VOLT_NEG_START)) ||
                    (vq_code > mad_pkg::VOLT_NEG_LIMIT)))
            |=> volt_code_invalid;
    endproperty
    a_invalid: assert property (p_invalid) else $error("bad voltage code not flagged");

    property p_start;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && reg_wdata[mad_pkg::START_BIT] && !meas.busy &&
         (reg_wdata[mad_pkg::EN_RES_BIT:mad_pkg::EN_MECH_BIT] != 4'h0))
            |=> meas.start ##1 meas_busy;
    endproperty
    a_start: assert property (p_start) else $error("start write did not launch a run");

    // back-to-back shadow writes legally give a two-cycle pulse
    property p_shadow;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_ovr && reg_wdata[mad_pkg::SHADOW_BIT])
            |=> shadow_store ##1
                (shadow_store == $past(wr_ovr && reg_wdata[mad_pkg::SHADOW_BIT]));
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow copy not a single pulse");

    property p_inner_gain;
        @(posedge ref_clk) disable iff (!nrst)
        (reg_rd && (reg_addr == mad_pkg::INNER_GAIN_OFFSET))
            |=> reg_ack && (reg_rdata == {6'h00, $past(inner_ki), 6'h00, $past(inner_kp)});
    endproperty
    a_inner_gain: assert property (p_inner_gain) else $error("inner gain bad");

    property p_vel_gain;
        @(posedge ref_clk) disable iff (!nrst)
        (reg_rd && (reg_addr == mad_pkg::VEL_GAIN_OFFSET))
            |=> (reg_rdata == {6'h00, $past(vel_ki), 6'h00, $past(vel_kp)});
    endproperty
    a_vel_gain: assert property (p_vel_gain) else $error("velocity gain bad");

    property p_rsvd;
        @(posedge ref_clk) disable iff (!nrst)
        $past(reg_rd) |-> (reg_rdata[31:mad_pkg::RSVD_LSB] == 5'h00);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

endmodule

//--- verilog/mad_meas_if.sv
// carrier between the register bank and the measurement sequencer
interface mad_meas_if;
    logic       start;
    logic [3:0] en;
    logic       busy;

    modport ctrl (output start, output en, input busy);
    modport seq  (input start, input en, output busy);
endinterface

//--- verilog/mad_meas_seq.sv
// sequencer that walks the enabled motor parameter measurements in order
module mad_meas_seq (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // control from the register bank
    mad_meas_if.seq         meas,
    // measurement engine handshake
    output logic            step_req,
    output logic [1:0]      step_sel,
    input  wire logic       step_done
);

    typedef struct packed {
        mad_pkg::mad_step_type step;
        logic [3:0]            en;
    } mad_seq_state_type;

    mad_seq_state_type s_q;
    mad_seq_state_type s_d;

    // first enabled step after position 'from' (en[3]=res .. en[0]=mech)
    function automatic mad_pkg::mad_step_type next_step(input logic [2:0] from,
                                                        input logic [3:0] en);
        mad_pkg::mad_step_type r;
        r = mad_pkg::MAD_IDLE;
        for (int i = 4; i >= 1; i--) begin
            if ((i > from) && en[4 - i]) begin
                r = mad_pkg::mad_step_type'(3'(i));
            end
        end
        return r;
    endfunction

    always_comb begin
        s_d = s_q;
        if (s_q.step == mad_pkg::MAD_IDLE) begin
            if (meas.start) begin
                // enables sampled with the start write; later writes do not disturb a run
                s_d.en   = meas.en;
                s_d.step = next_step(3'h0, meas.en);
            end
        end else if (step_done) begin
            s_d.step = next_step(s_q.step, s_q.en);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{step: mad_pkg::MAD_IDLE, en: mad_pkg::EN_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign meas.busy = (s_q.step != mad_pkg::MAD_IDLE);
    assign step_req  = meas.busy;
    assign step_sel  = 2'(s_q.step - 3'h1);

    ////////////////////////////////////////////////////////////////////////////

    property p_res_gated;
        @(posedge ref_clk) disable iff (!nrst)
        (s_q.step == mad_pkg::MAD_RES) |-> s_q.en[3];
    endproperty
    a_res_gated: assert property (p_res_gated) else $error("resistance step disabled");

    property p_ind_gated;
        @(posedge ref_clk) disable iff (!nrst)
        (meas.start && !meas.busy && meas.en[2] && !meas.en[3])
            |=> (s_q.step == mad_pkg::MAD_IND);
    endproperty
    a_ind_gated: assert property (p_ind_gated) else $error("inductance step missed");

    property p_bemf_gated;
        @(posedge ref_clk) disable iff (!nrst)
        (s_q.step == mad_pkg::MAD_BEMF) |-> s_q.en[1];
    endproperty
    a_bemf_gated: assert property (p_bemf_gated) else $error("bemf step not enabled");

    property p_mech_gated;
        @(posedge ref_clk) disable iff (!nrst)
        (s_q.step == mad_pkg::MAD_BEMF && step_done && s_q.en[0])
            |=> (s_q.step == mad_pkg::MAD_MECH);
    endproperty
    a_mech_gated: assert property (p_mech_gated) else $error("mechanical step missed");

endmodule

//--- verilog/mad_pkg.sv
// shared constants, types and helpers of the motor algorithm debug register bank
package mad_pkg;

    // register offsets on the serial register port
    localparam logic [7:0] OVR_CTRL_OFFSET    = 8'hEE;
    localparam logic [7:0] INNER_GAIN_OFFSET  = 8'hF0;
    localparam logic [7:0] VEL_GAIN_OFFSET    = 8'hF2;

    // override/measurement control field positions
    localparam int BYPASS_BIT       = 26;
    localparam int VD_MSB           = 25;
    localparam int VD_LSB           = 16;
    localparam int VQ_MSB           = 15;
    localparam int VQ_LSB           = 6;
    localparam int START_BIT        = 5;
    localparam int EN_RES_BIT       = 4;
    localparam int EN_IND_BIT       = 3;
    localparam int EN_BEMF_BIT      = 2;
    localparam int EN_MECH_BIT      = 1;
    localparam int SHADOW_BIT       = 0;
    localparam int RSVD_LSB         = 27;

    // gain readback field positions
    localparam int GAIN_HI_LSB      = 16;
    localparam int GAIN_LO_LSB      = 0;
    localparam int GAIN_W           = 10;

    // forced voltage code decoding
    localparam logic [9:0]  VOLT_POS_LIMIT  = 10'h1F4;
    localparam logic [9:0]  VOLT_NEG_START  = 10'h200;
    localparam logic [9:0]  VOLT_NEG_LIMIT  = 10'h3E8;
    localparam logic signed [10:0] VOLT_WRAP = 11'sh400;

    // values after reset
    localparam logic [9:0]  VOLT_RESET      = 10'h000;
    localparam logic [3:0]  EN_RESET        = 4'h0;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

    typedef enum logic [2:0] {
        MAD_IDLE = 3'b000,
        MAD_RES  = 3'b001,
        MAD_IND  = 3'b010,
        MAD_BEMF = 3'b011,
        MAD_MECH = 3'b100
    } mad_step_type;

    // signed numerator of the forced reference; the reference is num/500
    function automatic logic signed [10:0] decode_volt(input logic [9:0] raw);
        if (raw > VOLT_NEG_START) begin
            return $signed({1'b0, raw}) - VOLT_WRAP;
        end
        return $signed({1'b0, raw});
    endfunction

    // code that software should never write
    function automatic logic volt_invalid(input logic [9:0] raw);
        return ((raw > VOLT_POS_LIMIT) && (raw < VOLT_NEG_START)) || (raw > VOLT_NEG_LIMIT);
    endfunction

endpackage
